// ---- rtl/seic_pkg.sv ----
// Shared constants, types and calendar helpers for the scheduled integration block
package seic_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_KHZ  = 40000;
  localparam int TICK_MS  = 1000;
  localparam int TICK_CYC = CLK_KHZ * TICK_MS;
  localparam int ZCAL_S   = 3600;
  localparam int MAX_H    = 10000;
  localparam int MAX_S    = MAX_H * 3600;
  localparam int ZCAL_CYC = 16;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_CMD   = 8'h04;
  localparam logic [7:0] A_TMR_H = 8'h08;
  localparam logic [7:0] A_TMR_M = 8'h0C;
  localparam logic [7:0] A_BEG_D = 8'h10;
  localparam logic [7:0] A_BEG_T = 8'h14;
  localparam logic [7:0] A_END_D = 8'h18;
  localparam logic [7:0] A_END_T = 8'h1C;
  localparam logic [7:0] A_NOW_D = 8'h20;
  localparam logic [7:0] A_NOW_T = 8'h24;
  localparam logic [7:0] A_STAT  = 8'h28;
  localparam logic [7:0] A_ELAP  = 8'h2C;
  localparam logic [7:0] A_DPOS  = 8'h30;
  localparam logic [7:0] A_DNEG  = 8'h34;
  localparam logic [7:0] A_DTIM  = 8'h38;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int F_MODE = 0;
  localparam int F_ACAL = 2;
  localparam int F_METH = 3;
  localparam int C_SS   = 0;
  localparam int C_HOLD = 1;
  localparam int C_SGL  = 2;
  localparam int C_RST  = 3;
  localparam int S_HOLD = 2;
  localparam int S_VAL  = 3;
  localparam int S_DERR = 4;
  localparam int S_LIM  = 5;
  localparam int S_ZCAL = 6;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] MODE_NORM = 2'h0;
  localparam logic [1:0] MODE_CONT = 2'h1;
  localparam logic [1:0] MODE_SCH  = 2'h2;
  localparam logic [1:0] MODE_SREP = 2'h3;

  typedef enum logic [1:0] {ST_RESET, ST_READY, ST_START, ST_STOP} seic_state_t;

  function automatic logic [4:0] days_in(input logic [13:0] y, input logic [3:0] m);
    logic lp;
    lp = ((y % 4) == 0 && (y % 100) != 0) || (y % 400) == 0;
    case (m)
      4'h2:                   days_in = lp ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: days_in = 5'h1E;
      default:                days_in = 5'h1F;
    endcase
  endfunction : days_in

  function automatic logic dt_ok(input logic [31:0] d, input logic [31:0] t);
    dt_ok = d[11:8] >= 4'h1 && d[11:8] <= 4'hC && d[4:0] >= 5'h01 &&
            d[4:0] <= days_in(d[29:16], d[11:8]) &&
            t[20:16] < 5'h18 && t[13:8] < 6'h3C && t[5:0] < 6'h3C;
  endfunction : dt_ok

endpackage : seic_pkg

// ---- rtl/seic_cal.sv ----
// Calendar clock, advanced by the one-second tick, loadable by software
`timescale 1ns/1ps
module seic_cal (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        tick_i,
  input  wire logic        ld_date_i,
  input  wire logic        ld_time_i,
  input  wire logic [31:0] dat_i,
  output logic      [39:0] now_o
);
  import seic_pkg::*;

  logic [13:0] yr_r;
  logic [3:0]  mo_r;
  logic [4:0]  dy_r;
  logic [4:0]  hr_r;
  logic [5:0]  mi_r;
  logic [5:0]  sc_r;

  wire s_wrap = sc_r == 6'h3B;
  wire m_wrap = s_wrap && mi_r == 6'h3B;
  wire h_wrap = m_wrap && hr_r == 5'h17;
  wire d_wrap = h_wrap && dy_r >= days_in(yr_r, mo_r);
  wire y_wrap = d_wrap && mo_r == 4'hC;

  assign now_o = {yr_r, mo_r, dy_r, hr_r, mi_r, sc_r};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {yr_r, mo_r, dy_r} <= {14'h0000, 4'h1, 5'h01};
      {hr_r, mi_r, sc_r} <= 17'h00000;
    end else if (ld_date_i || ld_time_i) begin
      if (ld_date_i) {yr_r, mo_r, dy_r} <= {dat_i[29:16], dat_i[11:8], dat_i[4:0]};
      if (ld_time_i) {hr_r, mi_r, sc_r} <= {dat_i[20:16], dat_i[13:8], dat_i[5:0]};
    end else if (tick_i) begin
      // Leap-year aware day rollover
      sc_r <= s_wrap ? 6'h00 : sc_r + 6'h01;
      if (s_wrap) mi_r <= m_wrap ? 6'h00 : mi_r + 6'h01;
      if (m_wrap) hr_r <= h_wrap ? 5'h00 : hr_r + 5'h01;
      if (h_wrap) dy_r <= d_wrap ? 5'h01 : dy_r + 5'h01;
      if (d_wrap) mo_r <= y_wrap ? 4'h1 : mo_r + 4'h1;
      if (y_wrap) yr_r <= yr_r + 14'h0001;
    end
  end

endmodule : seic_cal

// ---- rtl/seic_acc.sv ----
// Saturation-checked signed accumulator for one polarity
`timescale 1ns/1ps
module seic_acc #(
  parameter int ACC_W = 32,
  parameter int SMP_W = 16
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    clr_i,
  input  wire logic                    add_i,
  input  wire logic signed [SMP_W-1:0] val_i,
  output logic signed      [ACC_W-1:0] acc_o,
  output logic                         lim_o
);
  logic signed [ACC_W:0] sum_w;

  assign sum_w = {acc_o[ACC_W-1], acc_o} + (ACC_W + 1)'(val_i);
  // Refusing the add keeps the value from before the overflowing sample
  assign lim_o = add_i && (sum_w[ACC_W] != sum_w[ACC_W-1]);

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      acc_o <= '0;
    end else if (add_i && !lim_o) begin
      acc_o <= sum_w[ACC_W-1:0];
    end
  end

endmodule : seic_acc

// ---- rtl/seic_top.sv ----
// Scheduled energy integration controller with a Wishbone register port
//
// Functional notes
// - Mode field offers single and repeating schedule
// - Start/stop from idle arms Ready only in schedule modes; otherwise it starts at once
// - Ready becomes Start at start time
// - Hold freezes display; second hold refreshes
// - Single command updates display once under hold
// - Start/stop while running stops, keeps values
// - Start/stop before end time resumes accumulation
// - Single schedule stops at end time
// - Repeating schedule restarts at each timer expiry
// - Reset clears values and marks no data
// - Timer expiry or 10000 hours stops single
// - Accumulator limit stops and holds
// - Timer spans zero to 10000 hours exactly
// - Zero timer runs until end or limits
// - Schedule holds year, month, day, time
// - Bad date flagged at launch only
// - Calendar obeys Gregorian leap years
// - Hourly zero compensation only when enabled
// - During compensation add last measured value
// - Polarity method: raw samples or updates
`timescale 1ns/1ps
module seic_top #(
  parameter int TICK_N = seic_pkg::TICK_CYC,
  parameter int ACC_W  = 32,
  parameter int SMP_W  = 16
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    smp_vld_i,
  input  wire logic signed [SMP_W-1:0] smp_i,
  input  wire logic                    upd_i,
  output logic                         zcal_o,
  output seic_pkg::seic_state_t        state_o,
  output logic                         hold_o
);
  import seic_pkg::*;
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] tmr_h_r;
  logic [31:0] tmr_m_r;
  logic [31:0] beg_d_r;
  logic [31:0] beg_t_r;
  logic [31:0] end_d_r;
  logic [31:0] end_t_r;
  logic [31:0] rd_w;
  logic [31:0] wmask_w;
  logic [3:0]  cmd_r;
  wire req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_w  = req_w && wb_we_i;
  assign wmask_w = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wd_w   = wb_dat_i & wmask_w;
  wire        wr_cmd = wr_w && wb_adr_i == A_CMD;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old & ~m) | (d & m);
  endfunction : merge

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cmd_r    <= 4'h0;
    end else begin
      wb_ack_o <= req_w;
      wb_dat_o <= req_w ? rd_w : 32'h0000_0000;
      cmd_r    <= wr_cmd ? wd_w[3:0] : 4'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r  <= CTRL_RST;
      tmr_h_r <= 32'h0000_0000;
      tmr_m_r <= 32'h0000_0000;
      beg_d_r <= 32'h0000_0000;
      beg_t_r <= 32'h0000_0000;
      end_d_r <= 32'h0000_0000;
      end_t_r <= 32'h0000_0000;
    end else if (wr_w) begin
      // Dates are stored unchecked; validity is judged at launch
      if (wb_adr_i == A_CTRL)  ctrl_r  <= merge(ctrl_r,  wmask_w, wb_dat_i);
      if (wb_adr_i == A_TMR_H) tmr_h_r <= merge(tmr_h_r, wmask_w, wb_dat_i);
      if (wb_adr_i == A_TMR_M) tmr_m_r <= merge(tmr_m_r, wmask_w, wb_dat_i);
      if (wb_adr_i == A_BEG_D) beg_d_r <= merge(beg_d_r, wmask_w, wb_dat_i);
      if (wb_adr_i == A_BEG_T) beg_t_r <= merge(beg_t_r, wmask_w, wb_dat_i);
      if (wb_adr_i == A_END_D) end_d_r <= merge(end_d_r, wmask_w, wb_dat_i);
      if (wb_adr_i == A_END_T) end_t_r <= merge(end_t_r, wmask_w, wb_dat_i);
    end
  end
  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  wire [1:0] mode_w = ctrl_r[F_MODE +: 2];
  wire sched_w = mode_w == MODE_SCH || mode_w == MODE_SREP;
  wire rep_w   = mode_w == MODE_SREP;
  wire acal_w  = ctrl_r[F_ACAL];
  wire meth_w  = ctrl_r[F_METH];
  wire ss_p    = cmd_r[C_SS];
  wire hold_p  = cmd_r[C_HOLD];
  wire sgl_p   = cmd_r[C_SGL];
  wire rst_p   = cmd_r[C_RST];

  // Hours clamp at 10000 and minutes/seconds are then forced to zero
  wire h_max = tmr_h_r[13:0] >= 14'(MAX_H);
  wire [31:0] tmr_s_w = h_max ? 32'(MAX_S) :
    32'(tmr_h_r[13:0]) * 32'h0000_0E10 + 32'(tmr_m_r[13:8]) * 32'h0000_003C + 32'(tmr_m_r[5:0]);
  wire tmr_on = tmr_s_w != 32'h0000_0000;
  // ----------------------------------------
  // One-second timebase and calendar
  // ----------------------------------------
  logic [31:0] div_r;
  logic        tick_r;
  logic [39:0] now_w;

  always_ff @(posedge clk_i) begin
    if (rst_i || div_r == 32'(TICK_N - 1)) begin
      div_r  <= 32'h0000_0000;
      tick_r <= !rst_i;
    end else begin
      div_r  <= div_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end

  seic_cal u_cal (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick_r),
    .ld_date_i (wr_w && wb_adr_i == A_NOW_D),
    .ld_time_i (wr_w && wb_adr_i == A_NOW_T),
    .dat_i     (merge(32'h0000_0000, wmask_w, wb_dat_i)),
    .now_o     (now_w)
  );

  // Packed {year,month,day,hour,min,sec} compares as one number
  wire [39:0] beg_w = {beg_d_r[29:16], beg_d_r[11:8], beg_d_r[4:0],
                       beg_t_r[20:16], beg_t_r[13:8], beg_t_r[5:0]};
  wire [39:0] end_w = {end_d_r[29:16], end_d_r[11:8], end_d_r[4:0],
                       end_t_r[20:16], end_t_r[13:8], end_t_r[5:0]};
  wire at_beg  = now_w >= beg_w;
  wire at_end  = now_w >= end_w;
  wire date_ok = dt_ok(beg_d_r, beg_t_r) && dt_ok(end_d_r, end_t_r);
  // ----------------------------------------
  // Integration state
  // ----------------------------------------
  seic_state_t st_r;
  logic [31:0] el_r;
  logic        val_r;
  logic        derr_r;
  logic        lim_r;
  logic        clr_r;
  logic [1:0]  lim_w;
  wire run_w   = st_r == ST_START;
  wire [31:0] el_nxt_w = el_r + 32'h0000_0001;
  wire tmr_exp = tmr_on && el_nxt_w >= tmr_s_w;
  wire any_lim = |lim_w;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r   <= ST_RESET;
      el_r   <= 32'h0000_0000;
      val_r  <= 1'b0;
      derr_r <= 1'b0;
      lim_r  <= 1'b0;
      clr_r  <= 1'b0;
    end else begin
      clr_r <= 1'b0;
      if (rst_p) begin
        st_r  <= ST_RESET;
        el_r  <= 32'h0000_0000;
        val_r <= 1'b0;
        lim_r <= 1'b0;
        clr_r <= 1'b1;
      end else if (ss_p) begin
        case (st_r)
          ST_RESET: begin
            derr_r <= sched_w && !date_ok;
            if (!sched_w) begin
              st_r  <= ST_START;
              val_r <= 1'b1;
            end else if (date_ok) begin
              st_r <= ST_READY;
            end
          end
          ST_READY: st_r <= ST_RESET;
          ST_START: st_r <= ST_STOP;
          ST_STOP:  if (!lim_r && !(sched_w && at_end)) st_r <= ST_START;
          default:  st_r <= ST_RESET;
        endcase
      end else if (run_w && any_lim) begin
        st_r  <= ST_STOP;
        lim_r <= 1'b1;
      end else if (tick_r && st_r == ST_READY && at_beg) begin
        st_r  <= ST_START;
        val_r <= 1'b1;
      end else if (tick_r && run_w) begin
        el_r <= el_nxt_w;
        if (sched_w && at_end) begin
          st_r <= ST_STOP;
        end else if (rep_w && tmr_exp) begin
          el_r  <= 32'h0000_0000;
          clr_r <= 1'b1;
        end else if (!rep_w && (tmr_exp || el_nxt_w > 32'(MAX_S))) begin
          st_r <= ST_STOP;
        end
      end
    end
  end
  // ----------------------------------------
  // Zero compensation and accumulation
  // ----------------------------------------
  logic [11:0]             hr_cnt_r;
  logic [7:0]              zc_cnt_r;
  logic signed [SMP_W-1:0] last_r;
  logic signed [ACC_W-1:0] acc_w [2];

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_w || !acal_w) begin
      hr_cnt_r <= 12'h000;
      zc_cnt_r <= 8'h00;
      zcal_o   <= 1'b0;
    end else begin
      if (tick_r) hr_cnt_r <= (hr_cnt_r == 12'(ZCAL_S - 1)) ? 12'h000 : hr_cnt_r + 12'h001;
      if (tick_r && hr_cnt_r == 12'(ZCAL_S - 1)) begin
        zcal_o   <= 1'b1;
        zc_cnt_r <= 8'(ZCAL_CYC - 1);
      end else if (zc_cnt_r != 8'h00) begin
        zc_cnt_r <= zc_cnt_r - 8'h01;
      end else begin
        zcal_o <= 1'b0;
      end
    end
  end

  // Measured value frozen while the zero level is being compensated
  always_ff @(posedge clk_i) begin
    if (rst_i) last_r <= '0;
    else if (smp_vld_i && !zcal_o) last_r <= smp_i;
  end

  wire signed [SMP_W-1:0] add_val = zcal_o ? last_r : smp_i;
  // Raw samples each, or one value per update interval
  wire add_ev = run_w && (meth_w ? upd_i : (smp_vld_i || zcal_o));

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pol
      seic_acc #(.ACC_W(ACC_W), .SMP_W(SMP_W)) u_acc (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .clr_i (clr_r),
        .add_i (add_ev && (add_val[SMP_W-1] == (p == 1))),
        .val_i (add_val),
        .acc_o (acc_w[p]),
        .lim_o (lim_w[p])
      );
    end
  endgenerate
  // ----------------------------------------
  // Display hold
  // ----------------------------------------
  logic [31:0] dpos_r;
  logic [31:0] dneg_r;
  logic [31:0] dtim_r;
  logic        sgl_r;
  wire disp_ld = rst_p || (!hold_o && (upd_i || hold_p)) || (hold_o && (hold_p || (sgl_r && upd_i)));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_o <= 1'b0;
      sgl_r  <= 1'b0;
    end else begin
      if (hold_p) hold_o <= !hold_o;
      if (sgl_p && hold_o) sgl_r <= 1'b1;
      else if (upd_i || hold_p) sgl_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dpos_r <= 32'h0000_0000;
      dneg_r <= 32'h0000_0000;
      dtim_r <= 32'h0000_0000;
    end else if (disp_ld) begin
      dpos_r <= rst_p ? 32'h0000_0000 : 32'(acc_w[0]);
      dneg_r <= rst_p ? 32'h0000_0000 : 32'(acc_w[1]);
      dtim_r <= rst_p ? 32'h0000_0000 : el_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) state_o <= ST_RESET;
    else state_o <= st_r;
  end
  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  wire [31:0] stat_w = {25'h0, zcal_o, lim_r, derr_r, val_r, hold_o, st_r};
  always_comb begin
    case (wb_adr_i)
      A_CTRL:  rd_w = ctrl_r;
      A_TMR_H: rd_w = tmr_h_r;
      A_TMR_M: rd_w = tmr_m_r;
      A_BEG_D: rd_w = beg_d_r;
      A_BEG_T: rd_w = beg_t_r;
      A_END_D: rd_w = end_d_r;
      A_END_T: rd_w = end_t_r;
      A_NOW_D: rd_w = {2'h0, now_w[39:26], 4'h0, now_w[25:22], 3'h0, now_w[21:17]};
      A_NOW_T: rd_w = {11'h0, now_w[16:12], 2'h0, now_w[11:6], 2'h0, now_w[5:0]};
      A_STAT:  rd_w = stat_w;
      A_ELAP:  rd_w = el_r;
      A_DPOS:  rd_w = dpos_r;
      A_DNEG:  rd_w = dneg_r;
      A_DTIM:  rd_w = dtim_r;
      default: rd_w = 32'h0000_0000;
    endcase
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_armed;
    st_r == ST_RESET && ss_p && !rst_p && sched_w && date_ok;
  endsequence
  sequence s_go;
    st_r == ST_READY && tick_r && at_beg && !ss_p && !rst_p;
  endsequence

  ready_arm_a: assert property (s_armed |=> st_r == ST_READY && el_r == $past(el_r))
    else $error("idle start/stop did not arm");
  sched_go_a: assert property (s_go |=> run_w ##1 state_o == ST_START)
    else $error("start time did not begin integration");
  hold_freeze_a: assert property (hold_o && !hold_p && !sgl_r && !rst_p |=> $stable(dpos_r))
    else $error("held display changed");
  single_upd_a: assert property (hold_o && sgl_r && upd_i && !hold_p && !rst_p |=> hold_o && !sgl_r)
    else $error("single update broke hold");
  stop_keep_a: assert property (st_r == ST_STOP && !rst_p && !ss_p |=> $stable(el_r))
    else $error("stopped time moved");
  end_stop_a: assert property (run_w && tick_r && sched_w && at_end && !rst_p && !ss_p && !any_lim
                               |=> st_r == ST_STOP)
    else $error("end time did not stop");
  rep_restart_a: assert property (run_w && tick_r && rep_w && tmr_exp && !at_end && !rst_p && !ss_p &&
                                  !any_lim |=> el_r == 32'h0000_0000 && clr_r ##1 acc_w[0] == '0)
    else $error("repeat did not restart");
  reset_clr_a: assert property (rst_p |=> st_r == ST_RESET && el_r == 32'h0000_0000 && !val_r)
    else $error("reset did not clear");
  limit_stop_a: assert property (run_w && any_lim && !rst_p && !ss_p |=> st_r == ST_STOP && lim_r)
    else $error("limit did not stop");
  zcal_gate_a: assert property ($rose(zcal_o) |-> $past(acal_w) && $past(run_w))
    else $error("compensation outside enabled run");
endmodule : seic_top

// ---- tb/seic_src.sv ----
// Measurement front-end model feeding samples and update strobes
`timescale 1ns/1ps
module seic_src (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic        [15:0] val_i,
  output logic                    smp_vld_o,
  output logic signed      [15:0] smp_o,
  output logic                    upd_o
);
  logic [3:0]  cnt_r;
  logic [15:0] last_r;
  // ----------------------------------------
  // Sample every 4 cycles, update every 16
  // ----------------------------------------
  // Between samples the data line shows junk, never a stale copy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r     <= 4'h0;
      last_r    <= 16'h0000;
      smp_vld_o <= 1'b0;
      upd_o     <= 1'b0;
      smp_o     <= 16'h0000;
    end else begin
      cnt_r     <= cnt_r + 4'h1;
      smp_vld_o <= (cnt_r[1:0] == 2'h3);
      upd_o     <= (cnt_r == 4'hF);
      if (cnt_r[1:0] == 2'h3) begin
        smp_o  <= val_i;
        last_r <= val_i;
      end else begin
        smp_o <= ~last_r;
      end
    end
  end
endmodule : seic_src

// ---- tb/seic_top_bench.sv ----
// Self-checking bench for the scheduled integration controller
`timescale 1ns/1ps
module seic_top_bench;
  import seic_pkg::*;
  logic               clk_i      = 1'b0;
  logic               rst_i      = 1'b1;
  logic               wb_cyc_i   = 1'b0;
  logic               wb_stb_i   = 1'b0;
  logic               wb_we_i    = 1'b0;
  logic [7:0]         wb_adr_i   = 8'h00;
  logic [3:0]         wb_sel_i   = 4'h0;
  logic [31:0]        wb_dat_i   = 32'h0000_0000;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o;
  logic               smp_vld_i;
  logic signed [15:0] smp_i;
  logic               upd_i;
  logic               zcal_o;
  seic_state_t        state_o;
  logic               hold_o;
  logic [31:0]        seed       = 32'h934CCEEC;
  logic [15:0]        rnd_val    = 16'h0000;
  logic [31:0]        rd;
  logic [31:0]        rd2;
  int                 fail_count = 0;
  int                 compares   = 0;
  int                 cyc_n      = 0;

  always #12.5 clk_i = ~clk_i;

  seic_top #(.TICK_N(20)) i_seic_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .smp_vld_i(smp_vld_i), .smp_i(smp_i), .upd_i(upd_i), .zcal_o(zcal_o),
    .state_o(state_o), .hold_o(hold_o));

  seic_src i_seic_src (.clk_i(clk_i), .rst_i(rst_i), .val_i(rnd_val), .smp_vld_o(smp_vld_i), .smp_o(smp_i),
    .upd_o(upd_i));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs

  function automatic logic [31:0] dw(input int y, input int m, input int d);
    dw = {2'h0, y[13:0], 4'h0, m[3:0], 3'h0, d[4:0]};
  endfunction : dw

  function automatic logic [31:0] tw(input int h, input int m, input int s);
    tw = {11'h000, h[4:0], 2'h0, m[5:0], 2'h0, s[5:0]};
  endfunction : tw

  task automatic stop_test();
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Random samples, watchdog, calibration monitor
  // ----------------------------------------
  always @(posedge clk_i) begin
    seed    <= xs(seed);
    rnd_val <= seed[15:0];
    cyc_n   <= cyc_n + 1;
    if (!rst_i && zcal_o === 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: compensation while disabled", $time);
    end
    if (cyc_n == 20000) begin
      fail_count++;
      $display("mismatch at %0t: timeout", $time);
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Holds the request until ack is sampled, as a classic single cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    chk({31'h0, n < 100}, 32'h1, "bus answer");
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] q;
    wb(1'b1, adr, dat, q);
  endtask : wr

  task automatic cmd(input int b);
    wr(A_CMD, 32'h0000_0001 << b);
  endtask : cmd

  task automatic wait_st(input seic_state_t s, input int lim, input string msg);
    int n;
    n = 0;
    while (state_o !== s && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk({30'h0, state_o}, {30'h0, s}, msg);
  endtask : wait_st

  task automatic sched(input logic [31:0] nd, input logic [31:0] nt, input logic [31:0] bd,
                       input logic [31:0] bt, input logic [31:0] ed, input logic [31:0] et);
    wr(A_NOW_D, nd);
    wr(A_NOW_T, nt);
    wr(A_BEG_D, bd);
    wr(A_BEG_T, bt);
    wr(A_END_D, ed);
    wr(A_END_T, et);
  endtask : sched

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({30'h0, state_o}, 32'h0, "reset state");
    wb(1'b0, A_STAT, 32'h0, rd);
    chk(rd, 32'h0, "reset status");
    wb(1'b0, 8'h3C, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    wb(1'b0, A_CMD, 32'h0, rd);
    chk(rd, 32'h0, "command reads zero");
    for (int i = 0; i < 2; i++) begin
      wr(A_CTRL, {28'h0, i[0], 1'b0, (i == 0) ? MODE_SCH : MODE_SREP});
      wb(1'b0, A_CTRL, 32'h0, rd);
      chk(rd, {28'h0, i[0], 1'b0, (i == 0) ? MODE_SCH : MODE_SREP}, "mode readback");
    end
    $display("test setup done");
    // Feb 29 in a common year is accepted, then refused at launch
    wr(A_CTRL, {30'h0, MODE_SCH});
    sched(dw(2023, 2, 1), tw(0, 0, 0), dw(2023, 2, 29), tw(0, 0, 1), dw(2023, 3, 1), tw(0, 0, 0));
    cmd(C_SS);
    repeat (6) @(posedge clk_i);
    wb(1'b0, A_STAT, 32'h0, rd);
    chk({31'h0, rd[S_DERR]}, 32'h1, "date error");
    chk({30'h0, rd[1:0]}, 32'h0, "stays idle on error");
    $display("test date error done");
    // Crosses into a leap day before the start
    sched(dw(2024, 2, 28), tw(23, 59, 58), dw(2024, 2, 29), tw(0, 0, 1), dw(2024, 2, 29), tw(0, 0, 20));
    cmd(C_SS);
    wait_st(ST_READY, 10, "armed");
    wait_st(ST_START, 200, "scheduled start");
    wb(1'b0, A_NOW_D, 32'h0, rd);
    chk(rd, dw(2024, 2, 29), "leap day");
    cmd(C_HOLD);
    repeat (4) @(posedge clk_i);
    chk({31'h0, hold_o}, 32'h1, "hold on");
    wb(1'b0, A_DPOS, 32'h0, rd);
    repeat (60) @(posedge clk_i);
    wb(1'b0, A_DPOS, 32'h0, rd2);
    chk(rd2, rd, "display frozen");
    cmd(C_SGL);
    repeat (40) @(posedge clk_i);
    chk({31'h0, hold_o}, 32'h1, "hold kept after single");
    wb(1'b0, A_DPOS, 32'h0, rd);
    chk({31'h0, rd != rd2}, 32'h1, "single refresh");
    cmd(C_HOLD);
    repeat (4) @(posedge clk_i);
    chk({31'h0, hold_o}, 32'h0, "hold off");
    cmd(C_SS);
    wait_st(ST_STOP, 10, "manual stop");
    wb(1'b0, A_ELAP, 32'h0, rd);
    repeat (45) @(posedge clk_i);
    wb(1'b0, A_ELAP, 32'h0, rd2);
    chk(rd2, rd, "elapsed held");
    cmd(C_SS);
    wait_st(ST_START, 10, "resume");
    wait_st(ST_STOP, 400, "end time stop");
    wb(1'b0, A_ELAP, 32'h0, rd);
    repeat (45) @(posedge clk_i);
    wb(1'b0, A_ELAP, 32'h0, rd2);
    chk(rd2, rd, "elapsed held at end");
    cmd(C_RST);
    wait_st(ST_RESET, 10, "reset");
    wb(1'b0, A_ELAP, 32'h0, rd);
    chk(rd, 32'h0, "elapsed cleared");
    wb(1'b0, A_STAT, 32'h0, rd);
    chk({31'h0, rd[S_VAL]}, 32'h0, "no data");
    $display("test single schedule done");
    // Repeating schedule, 3 second interval, across a year boundary
    wr(A_CTRL, {30'h0, MODE_SREP});
    wr(A_TMR_H, 32'h0);
    wr(A_TMR_M, 32'h3);
    sched(dw(2024, 12, 31), tw(23, 59, 59), dw(2025, 1, 1), tw(0, 0, 1), dw(2025, 1, 1), tw(0, 0, 40));
    cmd(C_SS);
    wait_st(ST_START, 200, "repeat start");
    for (int i = 0; i < 8; i++) begin
      repeat (20) @(posedge clk_i);
      wb(1'b0, A_ELAP, 32'h0, rd);
      chk({31'h0, rd < 32'h3}, 32'h1, "interval restart");
      chk({30'h0, state_o}, {30'h0, ST_START}, "still running");
    end
    cmd(C_RST);
    wait_st(ST_RESET, 10, "reset");
    $display("test repeating done");
    // Timer expiry ends a single schedule early
    wr(A_CTRL, {30'h0, MODE_SCH});
    wr(A_TMR_M, 32'h2);
    sched(dw(2025, 6, 30), tw(12, 0, 0), dw(2025, 6, 30), tw(12, 0, 1), dw(2025, 6, 30), tw(12, 0, 40));
    cmd(C_SS);
    wait_st(ST_START, 200, "timer start");
    wait_st(ST_STOP, 80, "timer stop");
    wb(1'b0, A_ELAP, 32'h0, rd);
    chk({31'h0, rd >= 32'h1 && rd <= 32'h3}, 32'h1, "elapsed at expiry");
    $display("test timer done");
    stop_test();
  end
endmodule : seic_top_bench
